//--- inc/scp_pkg.sv
// Shared constants and carriers for the strap configuration and monitor block.
// Assumes one 100 MHz clock and measurement words already digitised on that clock.
package scp_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int STRAP_SETTLE_NS = 1000;
    localparam int SETTLE_CYCLES   = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAL_TIME_NS     = 10000;
    localparam int CAL_CYCLES      = CAL_TIME_NS / CLK_PERIOD_NS;
    localparam int SETTLE_W        = 8;
    localparam int CAL_W           = 11;

    // Register offsets
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_VOUT_CMD  = 8'h04;
    localparam logic [7:0] REG_PHASE     = 8'h08;
    localparam logic [7:0] REG_GDRV      = 8'h0c;
    localparam logic [7:0] REG_STATUS    = 8'h10;
    localparam logic [7:0] REG_MASK      = 8'h14;
    localparam logic [7:0] REG_VIN_OV    = 8'h18;
    localparam logic [7:0] REG_VIN_UV    = 8'h1c;
    localparam logic [7:0] REG_VOUT_OV   = 8'h20;
    localparam logic [7:0] REG_VOUT_UV   = 8'h24;
    localparam logic [7:0] REG_IOUT_OC   = 8'h28;
    localparam logic [7:0] REG_OT        = 8'h2c;
    localparam logic [7:0] REG_READ_VIN  = 8'h30;
    localparam logic [7:0] REG_READ_VOUT = 8'h34;
    localparam logic [7:0] REG_READ_IOUT = 8'h38;
    localparam logic [7:0] REG_TEMP_1    = 8'h3c;
    localparam logic [7:0] REG_TEMP_2    = 8'h40;
    localparam logic [7:0] REG_INFO      = 8'h44;

    // Control bits
    localparam int CTRL_CAL_BIT   = 0;
    localparam int CTRL_STORE_BIT = 1;

    // Status bits
    localparam int STAT_W       = 7;
    localparam int ST_VIN_OV    = 0;
    localparam int ST_VIN_UV    = 1;
    localparam int ST_VOUT_OV   = 2;
    localparam int ST_VOUT_UV   = 3;
    localparam int ST_IOUT_OC   = 4;
    localparam int ST_OT        = 5;
    localparam int ST_CAL_DONE  = 6;

    // Info register fields
    localparam int INFO_TRACK   = 0;
    localparam int INFO_CAL     = 1;
    localparam int INFO_EXTTEMP = 2;
    localparam int INFO_NVM     = 3;
    localparam int INFO_EN      = 4;
    localparam int INFO_BAND_LO = 8;

    // Limits in mV
    localparam logic [15:0] VOUT_MIN_MV = 16'd500;
    localparam logic [15:0] VOUT_MAX_MV = 16'd5250;
    localparam logic [15:0] GDRV_MIN_MV = 16'd5000;
    localparam logic [15:0] GDRV_MAX_MV = 16'd8500;

    // Factory defaults
    localparam logic [15:0] DEF_GDRV_MV  = 16'd5000;
    localparam logic [15:0] DEF_VIN_OV   = 16'd14500;
    localparam logic [15:0] DEF_VIN_UV   = 16'd4200;
    localparam logic [15:0] DEF_VOUT_OV  = 16'd5500;
    localparam logic [15:0] DEF_VOUT_UV  = 16'd0;
    localparam logic [15:0] DEF_IOUT_OC  = 16'd30000;
    localparam logic [15:0] DEF_OT       = 16'd125;
    localparam logic [STAT_W-1:0] DEF_MASK = 7'h3f;

    // Strap decode
    localparam logic [4:0] BAND_TRACK = 5'h00;
    localparam logic [4:0] BAND_OPEN  = 5'h11;
    localparam logic [15:0] SET_MV [0:17] = '{16'd0, 16'd600, 16'd700, 16'd750, 16'd800,
        16'd850, 16'd900, 16'd950, 16'd1000, 16'd1050, 16'd1100, 16'd1200, 16'd1500,
        16'd1800, 16'd2500, 16'd3300, 16'd5000, 16'd0};
    localparam logic [8:0] PHASE_DEG [0:7] = '{9'd0, 9'd60, 9'd120, 9'd180, 9'd240,
        9'd300, 9'd90, 9'd270};

    typedef enum logic [1:0] {BOOT_SETTLE, BOOT_SAMPLE, BOOT_RESTORE, BOOT_RUN} scp_boot_t;

    typedef struct packed {
        logic [4:0] set_band;
        logic       set_tied_high;
        logic       set_tied_low;
        logic [2:0] addr_low;
    } scp_strap_t;

    typedef struct packed {
        logic [15:0] vin;
        logic [15:0] vout;
        logic [15:0] iout;
        logic [15:0] temp_int;
        logic [15:0] temp_ext;
    } scp_meas_t;

    typedef struct packed {
        logic        track;
        logic [15:0] vout_mv;
        logic [8:0]  phase;
        logic [15:0] gdrv_mv;
        logic [15:0] vin_ov;
        logic [15:0] vin_uv;
        logic [15:0] vout_ov;
        logic [15:0] vout_uv;
        logic [15:0] iout_oc;
        logic [15:0] ot;
    } scp_cfg_t;

endpackage

//--- rtl/scp_pin_sync.sv
// Three-stage input synchroniser with agreement filter for one pin.
// Assumes an asynchronous pin level; output follows once stages two and three agree.
`timescale 1ns/1ns
module scp_pin_sync (
    input  wire logic CLK_I,
    input  wire logic RESET_N_I,
    input  wire logic PIN_I,
    output logic      LEVEL_O
);
    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic q;
    } scp_sync_t;

    scp_sync_t s_reg;
    scp_sync_t s_next;

    always_comb begin
        s_next     = s_reg;
        s_next.ff1 = PIN_I;
        s_next.ff2 = s_reg.ff1;
        s_next.ff3 = s_reg.ff2;
        if (s_reg.ff2 == s_reg.ff3) begin
            s_next.q = s_reg.ff3;
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign LEVEL_O = s_reg.q;
endmodule

//--- rtl/scp_strap_config.sv
// Strap sampling, configuration registers, calibration start and monitor logic.
// Assumes strap bands and measurements arrive digitised on CLK_I; EN and
// the remote temperature ground detect are asynchronous pins.
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ns
module scp_strap_config (
    input  wire logic              CLK_I,
    input  wire logic              RESET_N_I,
    input  wire logic [7:0]        ADDR_I,
    input  wire logic [31:0]       WDATA_I,
    input  wire logic              WR_I,
    input  wire logic              RD_I,
    output logic      [31:0]       RDATA_O,
    input  wire scp_pkg::scp_strap_t STRAP_I,
    input  wire logic              NVM_VALID_I,
    input  wire scp_pkg::scp_cfg_t NVM_CFG_I,
    output logic                   NVM_STORE_O,
    output scp_pkg::scp_cfg_t      NVM_CFG_O,
    input  wire logic              EN_PIN_I,
    input  wire logic              REMOTE_TEMP_GND_I,
    input  wire scp_pkg::scp_meas_t MEAS_I,
    input  wire logic [15:0]       DUTY_CMD_I,
    output logic      [15:0]       DUTY_O,
    output logic                   CAL_START_O,
    output logic                   CAL_BUSY_O,
    output logic                   OUTPUT_EN_O,
    output logic                   TRACK_MODE_O,
    output logic      [15:0]       VOUT_MV_O,
    output logic      [8:0]        PHASE_DEG_O,
    output logic      [15:0]       GDRV_MV_O,
    output logic      [15:0]       TEMP_SEL_O,
    output logic                   ALERT_OUT_O,
    output logic                   ALERT_OE_O
);
    import scp_pkg::*;

    typedef struct packed {
        scp_boot_t           boot;
        logic [SETTLE_W-1:0] settle_cnt;
        logic                strapped;
        logic                from_nvm;
        logic [4:0]          band;
        scp_cfg_t            cfg;
        logic [STAT_W-1:0]   status;
        logic [STAT_W-1:0]   mask;
        scp_meas_t           meas;
        logic [15:0]         temp_sel;
        logic                en_d;
        logic                out_en;
        logic                cal_busy;
        logic [CAL_W-1:0]    cal_cnt;
        logic                cal_start;
        logic                nvm_store;
        logic [31:0]         rdata;
        logic [15:0]         duty;
        logic                alert;
    } scp_state_t;

    scp_state_t s_reg;
    scp_state_t s_next;
    logic       en_sync;
    logic       tgnd_sync;

    scp_pin_sync u_en_sync (
        .CLK_I     (CLK_I),
        .RESET_N_I (RESET_N_I),
        .PIN_I     (EN_PIN_I),
        .LEVEL_O   (en_sync)
    );

    scp_pin_sync u_tgnd_sync (
        .CLK_I     (CLK_I),
        .RESET_N_I (RESET_N_I),
        .PIN_I     (REMOTE_TEMP_GND_I),
        .LEVEL_O   (tgnd_sync)
    );

    function automatic logic [15:0] clamp16(input logic [15:0] v,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
        logic [15:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    always_comb begin
        logic              run;
        logic              wr;
        logic              cal_req;
        logic              en_rise;
        logic [4:0]        band;
        logic [STAT_W-1:0] set_bits;
        logic [STAT_W-1:0] clr_bits;
        logic [31:0]       rd;
        run      = (s_reg.boot == BOOT_RUN);
        wr       = WR_I && run;
        cal_req  = 1'b0;
        en_rise  = 1'b0;
        band     = STRAP_I.set_band;
        set_bits = '0;
        clr_bits = '0;
        rd       = '0;

        s_next           = s_reg;
        s_next.cal_start = 1'b0;
        s_next.nvm_store = 1'b0;
        s_next.rdata     = '0;

        // Power-up sequence
        unique case (s_reg.boot)
            BOOT_SETTLE: begin
                if (s_reg.settle_cnt == SETTLE_W'(SETTLE_CYCLES - 1)) begin
                    s_next.boot = BOOT_SAMPLE;
                end else begin
                    s_next.settle_cnt = s_reg.settle_cnt + 1'b1;
                end
            end
            BOOT_SAMPLE: begin
                if (STRAP_I.set_tied_low) begin
                    band = BAND_TRACK;
                end else if (STRAP_I.set_tied_high || STRAP_I.set_band > BAND_OPEN) begin
                    band = BAND_OPEN;
                end
                if (!s_reg.strapped) begin
                    s_next.strapped    = 1'b1;
                    s_next.band        = band;
                    s_next.cfg.track   = (band == BAND_TRACK);
                    s_next.cfg.vout_mv = SET_MV[band];
                    s_next.cfg.phase   = PHASE_DEG[STRAP_I.addr_low];
                    s_next.cfg.gdrv_mv = DEF_GDRV_MV;
                    s_next.cfg.vin_ov  = DEF_VIN_OV;
                    s_next.cfg.vin_uv  = DEF_VIN_UV;
                    s_next.cfg.vout_ov = DEF_VOUT_OV;
                    s_next.cfg.vout_uv = DEF_VOUT_UV;
                    s_next.cfg.iout_oc = DEF_IOUT_OC;
                    s_next.cfg.ot      = DEF_OT;
                end
                s_next.boot = BOOT_RESTORE;
            end
            BOOT_RESTORE: begin
                if (NVM_VALID_I) begin
                    s_next.cfg      = NVM_CFG_I;
                    s_next.from_nvm = 1'b1;
                end
                s_next.boot = BOOT_RUN;
            end
            BOOT_RUN: begin
                s_next.boot = BOOT_RUN;
            end
        endcase

        // Register writes
        if (wr) begin
            unique case (ADDR_I)
                REG_CTRL: begin
                    cal_req          = WDATA_I[CTRL_CAL_BIT];
                    s_next.nvm_store = WDATA_I[CTRL_STORE_BIT];
                end
                REG_VOUT_CMD: s_next.cfg.vout_mv =
                    clamp16(WDATA_I[15:0], VOUT_MIN_MV, VOUT_MAX_MV);
                REG_PHASE: begin
                    if (!en_sync) begin
                        s_next.cfg.phase = WDATA_I[8:0];
                    end
                end
                REG_GDRV: s_next.cfg.gdrv_mv =
                    clamp16(WDATA_I[15:0], GDRV_MIN_MV, GDRV_MAX_MV);
                REG_STATUS: clr_bits = WDATA_I[STAT_W-1:0];
                REG_MASK: s_next.mask = WDATA_I[STAT_W-1:0];
                REG_VIN_OV: s_next.cfg.vin_ov = WDATA_I[15:0];
                REG_VIN_UV: s_next.cfg.vin_uv = WDATA_I[15:0];
                REG_VOUT_OV: s_next.cfg.vout_ov = WDATA_I[15:0];
                REG_VOUT_UV: s_next.cfg.vout_uv = WDATA_I[15:0];
                REG_IOUT_OC: s_next.cfg.iout_oc = WDATA_I[15:0];
                REG_OT: s_next.cfg.ot = WDATA_I[15:0];
                default: ;
            endcase
        end

        // Enable tracking and calibration
        s_next.en_d   = en_sync;
        en_rise       = run && en_sync && !s_reg.en_d;
        s_next.out_en = run && en_sync;
        if ((en_rise || cal_req) && !s_reg.cal_busy) begin
            s_next.cal_start = 1'b1;
            s_next.cal_busy  = 1'b1;
            s_next.cal_cnt   = '0;
        end else if (s_reg.cal_busy) begin
            if (s_reg.cal_cnt == CAL_W'(CAL_CYCLES - 1)) begin
                s_next.cal_busy         = 1'b0;
                set_bits[ST_CAL_DONE]   = 1'b1;
            end else begin
                s_next.cal_cnt = s_reg.cal_cnt + 1'b1;
            end
        end

        // Duty path to the pulse modulator
        s_next.duty = s_reg.out_en ? DUTY_CMD_I : '0;

        // Monitoring
        s_next.meas     = MEAS_I;
        s_next.temp_sel = tgnd_sync ? s_reg.meas.temp_int
                                    : s_reg.meas.temp_ext;
        if (run) begin
            set_bits[ST_VIN_OV]  = s_reg.meas.vin  > s_reg.cfg.vin_ov;
            set_bits[ST_VIN_UV]  = s_reg.meas.vin  < s_reg.cfg.vin_uv;
            set_bits[ST_VOUT_OV] = s_reg.meas.vout > s_reg.cfg.vout_ov;
            set_bits[ST_VOUT_UV] = s_reg.out_en && s_reg.meas.vout < s_reg.cfg.vout_uv;
            set_bits[ST_IOUT_OC] = s_reg.meas.iout > s_reg.cfg.iout_oc;
            set_bits[ST_OT]      = s_reg.temp_sel  > s_reg.cfg.ot;
        end
        s_next.status = (s_reg.status & ~clr_bits) | set_bits;
        s_next.alert  = |(s_next.status & s_reg.mask);

        // Register reads
        unique case (ADDR_I)
            REG_VOUT_CMD:  rd = {16'h0000, s_reg.cfg.vout_mv};
            REG_PHASE:     rd = {23'h000000, s_reg.cfg.phase};
            REG_GDRV:      rd = {16'h0000, s_reg.cfg.gdrv_mv};
            REG_STATUS:    rd = {25'h0000000, s_reg.status};
            REG_MASK:      rd = {25'h0000000, s_reg.mask};
            REG_VIN_OV:    rd = {16'h0000, s_reg.cfg.vin_ov};
            REG_VIN_UV:    rd = {16'h0000, s_reg.cfg.vin_uv};
            REG_VOUT_OV:   rd = {16'h0000, s_reg.cfg.vout_ov};
            REG_VOUT_UV:   rd = {16'h0000, s_reg.cfg.vout_uv};
            REG_IOUT_OC:   rd = {16'h0000, s_reg.cfg.iout_oc};
            REG_OT:        rd = {16'h0000, s_reg.cfg.ot};
            REG_READ_VIN:  rd = {16'h0000, s_reg.meas.vin};
            REG_READ_VOUT: rd = {16'h0000, s_reg.meas.vout};
            REG_READ_IOUT: rd = {16'h0000, s_reg.meas.iout};
            REG_TEMP_1:    rd = {16'h0000, s_reg.meas.temp_int};
            REG_TEMP_2:    rd = {16'h0000, s_reg.meas.temp_ext};
            REG_INFO: begin
                rd[INFO_TRACK]                 = s_reg.cfg.track;
                rd[INFO_CAL]                   = s_reg.cal_busy;
                rd[INFO_EXTTEMP]               = !tgnd_sync;
                rd[INFO_NVM]                   = s_reg.from_nvm;
                rd[INFO_EN]                    = s_reg.out_en;
                rd[INFO_BAND_LO+4:INFO_BAND_LO] = s_reg.band;
            end
            default: rd = '0;
        endcase
        if (RD_I) begin
            s_next.rdata = rd;
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            s_reg      <= '0;
            s_reg.boot <= BOOT_SETTLE;
            s_reg.mask <= DEF_MASK;
        end else begin
            s_reg <= s_next;
        end
    end

    assign RDATA_O      = s_reg.rdata;
    assign NVM_STORE_O  = s_reg.nvm_store;
    assign NVM_CFG_O    = s_reg.cfg;
    assign DUTY_O       = s_reg.duty;
    assign CAL_START_O  = s_reg.cal_start;
    assign CAL_BUSY_O   = s_reg.cal_busy;
    assign OUTPUT_EN_O  = s_reg.out_en;
    assign TRACK_MODE_O = s_reg.cfg.track;
    assign VOUT_MV_O    = s_reg.cfg.vout_mv;
    assign PHASE_DEG_O  = s_reg.cfg.phase;
    assign GDRV_MV_O    = s_reg.cfg.gdrv_mv;
    assign TEMP_SEL_O   = s_reg.temp_sel;
    assign ALERT_OUT_O  = 1'b0;
    assign ALERT_OE_O   = s_reg.alert;
endmodule

//--- bench/scp_strap_chk.sv
// Concurrent checks on the strap configuration block ports.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ns
module scp_strap_chk (
    input wire logic        CLK_I,
    input wire logic        RESET_N_I,
    input wire logic        RD_I,
    input wire logic [31:0] RDATA_O,
    input wire logic [15:0] DUTY_CMD_I,
    input wire logic [15:0] DUTY_O,
    input wire logic        OUTPUT_EN_O,
    input wire logic        CAL_START_O,
    input wire logic        CAL_BUSY_O,
    input wire logic [15:0] VOUT_MV_O,
    input wire logic [15:0] GDRV_MV_O,
    input wire logic [8:0]  PHASE_DEG_O,
    input wire logic        ALERT_OUT_O
);
    import scp_pkg::*;
    logic [10:0] busy_cnt_reg;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    // Busy length counter
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            busy_cnt_reg <= 11'h0;
        end else begin
            busy_cnt_reg <= CAL_BUSY_O ? busy_cnt_reg + 11'h1 : 11'h0;
        end
    end
    a_read_slot_zero: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
        else $error("read data outside read slot");
    a_duty_follows: assert property (OUTPUT_EN_O && $past(OUTPUT_EN_O)
        |-> DUTY_O == $past(DUTY_CMD_I)) else $error("duty not passed through");
    a_duty_off_zero: assert property (!OUTPUT_EN_O && !$past(OUTPUT_EN_O)
        |-> DUTY_O == 16'h0) else $error("duty while disabled");
    a_cal_start_busy: assert property (CAL_START_O |=> CAL_BUSY_O && !CAL_START_O)
        else $error("calibration start not a pulse into busy");
    a_cal_busy_cause: assert property ($rose(CAL_BUSY_O) |-> CAL_START_O)
        else $error("busy without start");
    a_cal_busy_len: assert property ($fell(CAL_BUSY_O) |-> busy_cnt_reg == 11'h3e8)
        else $error("calibration length wrong");
    a_cal_busy_bound: assert property (CAL_BUSY_O |-> busy_cnt_reg < 11'h3e8)
        else $error("calibration overran");
    a_enable_cal: assert property ($rose(OUTPUT_EN_O) |-> ##[0:2] CAL_BUSY_O)
        else $error("no calibration on enable");
    a_phase_frozen: assert property (OUTPUT_EN_O && $past(OUTPUT_EN_O)
        |-> $stable(PHASE_DEG_O)) else $error("phase changed while enabled");
    a_alert_open_drain: assert property (ALERT_OUT_O == 1'b0)
        else $error("alert data not low");
    a_vout_range: assert property (VOUT_MV_O == 16'h0 ||
        (VOUT_MV_O >= VOUT_MIN_MV && VOUT_MV_O <= VOUT_MAX_MV)) else $error("vout range");
    a_gdrv_range: assert property (GDRV_MV_O == 16'h0 ||
        (GDRV_MV_O >= GDRV_MIN_MV && GDRV_MV_O <= GDRV_MAX_MV)) else $error("gdrv range");
endmodule
bind scp_strap_config scp_strap_chk i_chk (.CLK_I, .RESET_N_I, .RD_I, .RDATA_O, .DUTY_CMD_I,
    .DUTY_O, .OUTPUT_EN_O, .CAL_START_O, .CAL_BUSY_O, .VOUT_MV_O, .GDRV_MV_O, .PHASE_DEG_O,
    .ALERT_OUT_O);

//--- bench/scp_nvm_model.sv
// Nonvolatile store beside the block: keeps the last saved configuration.
// Assumes contents survive resets of the block, as flash does.
`timescale 1ns/1ns
module scp_nvm_model (
    input  wire logic             clk_i,
    input  wire logic             store_i,
    input  wire scp_pkg::scp_cfg_t cfg_i,
    output logic                  valid_o,
    output scp_pkg::scp_cfg_t     cfg_o
);
    import scp_pkg::*;
    scp_cfg_t mem_reg;
    initial begin
        valid_o = 1'b0;
        mem_reg = '0;
    end
    // Capture on store pulse
    always @(posedge clk_i) begin
        if (store_i === 1'b1) begin
            mem_reg <= cfg_i;
            valid_o <= 1'b1;
        end
    end
    // No saved copy: never show a usable value
    assign cfg_o = valid_o ? mem_reg : ~mem_reg;
endmodule

//--- bench/tb_strap_config_and_monitor.sv
// Self-checking bench for the strap configuration block.
// Assumes package, design, checker and store model compile ahead of it.
`timescale 1ns/1ns
module tb_strap_config_and_monitor;
    import scp_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        en_pin = 1'b0;
    logic        tgnd = 1'b0;
    logic [15:0] duty_cmd = 16'h0;
    scp_strap_t  strap = '0;
    scp_meas_t   meas = '{16'h2ee0, 16'h3e8, 16'h3e8, 16'h28, 16'h46};
    logic [31:0] rdata;
    logic        nvm_store, nvm_valid, cal_start, cal_busy, out_en, track, alert_out, alert_oe;
    scp_cfg_t    nvm_out, nvm_in;
    logic [15:0] duty, vout_mv, gdrv_mv, temp_sel, v;
    logic [8:0]  phase;
    logic [8:0]  ph [0:7] = '{9'h0, 9'h3c, 9'h78, 9'hb4, 9'hf0, 9'h12c, 9'h5a, 9'h10e};
    logic [15:0] cw [0:5] = '{16'h1f3, 16'h1483, 16'h4b0, 16'h1387, 16'h2135, 16'h1770};
    logic [15:0] ce [0:5] = '{16'h1f4, 16'h1482, 16'h4b0, 16'h1388, 16'h2134, 16'h1770};
    logic [15:0] dl [0:5] = '{DEF_VIN_OV, DEF_VIN_UV, DEF_VOUT_OV, DEF_VOUT_UV,
        DEF_IOUT_OC, DEF_OT};
    logic [31:0] expq [$];
    logic        rd_q = 1'b0;
    int          bad_count = 0;
    int          checks = 0;
    int          i;
    always #5 clk = ~clk;
    scp_strap_config i_dut (.CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .STRAP_I(strap), .NVM_VALID_I(nvm_valid),
        .NVM_CFG_I(nvm_in), .NVM_STORE_O(nvm_store), .NVM_CFG_O(nvm_out), .EN_PIN_I(en_pin),
        .REMOTE_TEMP_GND_I(tgnd), .MEAS_I(meas), .DUTY_CMD_I(duty_cmd), .DUTY_O(duty),
        .CAL_START_O(cal_start), .CAL_BUSY_O(cal_busy), .OUTPUT_EN_O(out_en),
        .TRACK_MODE_O(track), .VOUT_MV_O(vout_mv), .PHASE_DEG_O(phase), .GDRV_MV_O(gdrv_mv),
        .TEMP_SEL_O(temp_sel), .ALERT_OUT_O(alert_out), .ALERT_OE_O(alert_oe));
    scp_nvm_model i_nvm (.clk_i(clk), .store_i(nvm_store), .cfg_i(nvm_out),
        .valid_o(nvm_valid), .cfg_o(nvm_in));
    task automatic results();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    // Read results checked against oldest note
    always @(posedge clk) begin
        if (rd_q) begin
            chk(rdata, expq.pop_front(), "read data");
        end
        rd_q <= rd;
    end
    task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic wrt(input logic [7:0] a, input logic [31:0] d);
        bus(a, d, 1'b1);
    endtask
    task automatic rdx(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(a, 32'h0, 1'b0);
    endtask
    // Write then read with no gap
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        expq.push_back(e);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic wait_on(input int sel, input logic val, input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            if ((sel == 0 ? out_en : cal_busy) === val) return;
        end
        bad_count++;
        $display("CHECK FAILED %0t wait timed out", $time);
        results();
    endtask
    task automatic boot();
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (110) @(posedge clk);
    endtask
    initial begin
        i = $urandom(79409);
        for (i = 0; i < 20; i++) begin
            strap <= '{(i < 18) ? i[4:0] : 5'h3, i == 18, i == 19, i[2:0]};
            boot();
            chk(vout_mv, (i < 18) ? SET_MV[i] : 16'h0, "strap vout");
            chk(track, (i == 0 || i == 19), "track mode");
            chk(phase, ph[i[2:0]], "phase default");
        end
        strap <= '{5'h5, 1'b0, 1'b0, 3'h6};
        boot();
        strap <= '{5'h10, 1'b0, 1'b0, 3'h1};
        repeat (20) @(posedge clk);
        rdx(REG_VOUT_CMD, 32'h352);
        rdx(REG_PHASE, 32'h5a);
        rdx(REG_GDRV, {16'h0, DEF_GDRV_MV});
        rdx(REG_MASK, 32'h3f);
        for (i = 0; i < 6; i++) rdx(REG_VIN_OV + 8'(4 * i), {16'h0, dl[i]});
        rdx(REG_CTRL, 32'h0);
        rdx(8'h80, 32'h0);
        for (i = 0; i < 6; i++) begin
            wr_rd(i < 3 ? REG_VOUT_CMD : REG_GDRV, {16'h0, cw[i]}, {16'h0, ce[i]});
        end
        chk(gdrv_mv, 16'h1770, "gdrv pin");
        v = 16'(VOUT_MIN_MV + $urandom % 32'h128f);
        wr_rd(REG_VOUT_CMD, {16'h0, v}, {16'h0, v});
        chk(vout_mv, v, "vout pin");
        wrt(REG_CTRL, 32'h1);
        wait_on(1, 1'b1, 4);
        wrt(REG_CTRL, 32'h1);
        wait_on(1, 1'b0, 1100);
        rdx(REG_STATUS, 32'h40);
        wrt(REG_STATUS, 32'h7f);
        rdx(REG_STATUS, 32'h0);
        chk(temp_sel, 16'h46, "external temp");
        rdx(REG_TEMP_1, 32'h28);
        rdx(REG_TEMP_2, 32'h46);
        tgnd <= 1'b1;
        repeat (8) @(posedge clk);
        meas.temp_ext <= 16'hc8;
        repeat (5) @(posedge clk);
        chk(temp_sel, 16'h28, "internal temp");
        rdx(REG_STATUS, 32'h0);
        meas.temp_int <= 16'h96;
        meas.vin <= 16'h3a98;
        repeat (5) @(posedge clk);
        rdx(REG_STATUS, 32'h21);
        chk(alert_oe, 1'b1, "alert pulled");
        wrt(REG_OT, 32'hfa);
        wrt(REG_VIN_OV, 32'h3e80);
        wrt(REG_STATUS, 32'h7f);
        repeat (3) @(posedge clk);
        rdx(REG_STATUS, 32'h0);
        chk(alert_oe, 1'b0, "alert released");
        en_pin <= 1'b1;
        wait_on(0, 1'b1, 10);
        wait_on(1, 1'b1, 3);
        wrt(REG_PHASE, 32'hb4);
        rdx(REG_PHASE, 32'h5a);
        repeat (50) begin
            @(posedge clk);
            duty_cmd <= 16'($urandom);
        end
        wait_on(1, 1'b0, 1100);
        en_pin <= 1'b0;
        wait_on(0, 1'b0, 10);
        repeat (3) @(posedge clk);
        chk(duty, 16'h0, "duty off");
        wr_rd(REG_PHASE, 32'hb4, 32'hb4);
        wr_rd(REG_VOUT_CMD, 32'h4d2, 32'h4d2);
        wrt(REG_CTRL, 32'h2);
        // Let the store pulse reach the store before reset clears it
        repeat (2) @(posedge clk);
        boot();
        rdx(REG_VOUT_CMD, 32'h4d2);
        rdx(REG_PHASE, 32'hb4);
        rdx(REG_INFO, 32'h1008);
        rdx(REG_READ_VIN, 32'h3a98);
        chk(vout_mv, 16'h4d2, "restored vout");
        repeat (3) @(posedge clk);
        results();
    end
endmodule
